// *** acsc_pkg.sv ***
// constants for the converter start control block
// assumes a 32-bit axi4-lite slave port and a 50 MHz aclk
package acsc_pkg;
  localparam logic [31:0] CTRL_ADDR = 32'he0034000;
  localparam logic [31:0] GDR_ADDR = 32'he0034004;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  // used bits 19:0, 21, 27:24; reserved bits read zero
  localparam logic [31:0] CTRL_USED_MASK = 32'h0f2fffff;
  localparam int SEL_LSB = 0;
  localparam int DIV_LSB = 8;
  localparam int BURST_BIT = 16;
  localparam int LEN_LSB = 17;
  localparam int PWR_BIT = 21;
  localparam int SRC_LSB = 24;
  localparam int EDGE_BIT = 27;
  localparam int RES_LSB = 6;
  localparam int OVR_BIT = 30;
  localparam int DONE_BIT = 31;
  localparam logic [3:0] FULL_CLOCKS = 4'hb;
  localparam logic [3:0] FULL_BITS = 4'ha;
  localparam logic [2:0] SRC_NONE = 3'h0;
  localparam logic [2:0] SRC_NOW = 3'h1;
  localparam logic [2:0] SRC_FIRST_EDGE = 3'h2;
  localparam int NUM_EDGE_SRC = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : acsc_pkg

// *** acsc_edge_detect.sv ***
// two-flop synchronisers and edge detection for the start signals
// assumes start signals may be asynchronous to aclk
`timescale 1ns/10ps
module acsc_edge_detect #(
  parameter int N = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [N-1:0] sig_in,
  input wire logic falling,
  output logic [N-1:0] edge_hit
);
  logic [N-1:0] meta;
  logic [N-1:0] sync;
  logic [N-1:0] prev;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
    end
    else
    begin
      meta <= sig_in;
      sync <= meta;
      prev <= sync;
    end
  end

  // detect per line, so a change of selection makes no false edge
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_edge
      assign edge_hit[i] = falling ? (prev[i] & ~sync[i]) : (~prev[i] & sync[i]);
    end
  endgenerate
endmodule : acsc_edge_detect

// *** acsc_conv_seq.sv ***
// converter clock divider and conversion timing sequencer
// assumes core samples on conv_tick while busy
`timescale 1ns/10ps
module acsc_conv_seq (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic power_on,
  input wire logic start,
  input wire logic repeat_run,
  input wire logic [7:0] clk_div,
  input wire logic [3:0] conv_clocks,
  output logic conv_tick,
  output logic busy,
  output logic done
);
  logic [7:0] div_cnt;
  logic [3:0] clk_cnt;
  logic last_clock;

  assign conv_tick = power_on && (div_cnt == clk_div);
  assign last_clock = busy && conv_tick && (clk_cnt == conv_clocks - 4'h1);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !power_on)
      div_cnt <= 8'h00;
    else if (conv_tick)
      div_cnt <= 8'h00;
    else
      div_cnt <= div_cnt + 8'h01;
  end

  // powered down holds the core idle
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !power_on)
    begin
      busy <= 1'b0;
      clk_cnt <= 4'h0;
      done <= 1'b0;
    end
    else
    begin
      done <= last_clock;
      if (start || (!busy && repeat_run))
      begin
        busy <= 1'b1;
        clk_cnt <= 4'h0;
      end
      else if (last_clock)
      begin
        busy <= repeat_run;
        clk_cnt <= 4'h0;
      end
      else if (busy && conv_tick)
        clk_cnt <= clk_cnt + 4'h1;
    end
  end
endmodule : acsc_conv_seq

// *** acsc_top.sv ***
// converter start control: control register, start selection, done flag
// assumes an axi4-lite master, one write and one read in flight at most
// Overview of operation
// - three-bit length field, bits 19:17, resets zero
// - code 0 gives 11 clocks/10 bits, down to 4/3
// - bit 21 powers converter; zero powers down
// - source code 000 starts nothing without burst
// - source field 26:24 used without burst; 001 starts now
// - code 010 starts on shared interrupt pin edge
// - code 011 starts on port 0 pin 22 edge
// - codes 100/101 use timer 0 matches 1/3
// - codes 110/111 use timer 1 matches 0/1
// - edge bit 27 only matters for 010-111
// - edge bit one falling, zero rising
// - burst needs source 000 or nothing starts
// - without burst every conversion takes 11 clocks
// - converter clock is aclk over divider plus one
// - done flag set on finish, cleared by result register read or control write
`timescale 1ns/10ps
module acsc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic shared_interrupt_start_pin,
  input wire logic port0_pin22_start,
  input wire logic timer0_match1_out,
  input wire logic timer0_match3_out,
  input wire logic timer1_match0_out,
  input wire logic timer1_match1_out,
  input wire logic [9:0] core_result,
  output logic converter_power_on,
  output logic conv_start,
  output logic conv_tick,
  output logic conv_busy,
  output logic [3:0] conv_clocks,
  output logic [3:0] result_bits,
  output logic [7:0] channel_select
);
  logic [31:0] converter_control;
  logic [31:0] aw_addr;
  logic aw_full;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_full;
  logic done;
  logic overrun;
  logic [9:0] result;
  logic seq_done;

  // write channel: address and data taken in either order
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_full || aw_hs;
  wire w_have = w_full || w_hs;
  wire do_write = aw_have && w_have && !s_axi_bvalid;
  wire [31:0] wr_addr = aw_full ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_full ? w_data : s_axi_wdata;
  wire [3:0] wr_strb = w_full ? w_strb : s_axi_wstrb;
  wire ctrl_wr = do_write && (wr_addr == acsc_pkg::CTRL_ADDR);
  wire wr_mapped = (wr_addr == acsc_pkg::CTRL_ADDR);

  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready = !w_full && !s_axi_bvalid;

  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : strb_mask

  wire [31:0] wmask = strb_mask(wr_strb) & acsc_pkg::CTRL_USED_MASK;
  wire [31:0] next_ctrl = (converter_control & ~wmask) | (wr_data & wmask);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      aw_addr <= 32'h00000000;
    end
    else if (do_write)
      aw_full <= 1'b0;
    else if (aw_hs)
    begin
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end
    else if (do_write)
      w_full <= 1'b0;
    else if (w_hs)
    begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= acsc_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? acsc_pkg::RESP_OKAY : acsc_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // control register; reserved bits never stored
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      converter_control <= acsc_pkg::CTRL_RESET;
    else if (ctrl_wr)
      converter_control <= next_ctrl;
  end

  // field views
  wire burst_on = converter_control[acsc_pkg::BURST_BIT];
  wire [2:0] len_sel = converter_control[acsc_pkg::LEN_LSB +: 3];
  wire [2:0] start_src = converter_control[acsc_pkg::SRC_LSB +: 3];
  wire falling_sel = converter_control[acsc_pkg::EDGE_BIT];
  wire [7:0] clk_div = converter_control[acsc_pkg::DIV_LSB +: 8];
  wire power_on = converter_control[acsc_pkg::PWR_BIT];

  assign converter_power_on = power_on;
  assign channel_select = converter_control[acsc_pkg::SEL_LSB +: 8];
  // burst shortens the conversion; software mode is always full length
  assign conv_clocks = burst_on ? (acsc_pkg::FULL_CLOCKS - {1'b0, len_sel})
                                : acsc_pkg::FULL_CLOCKS;
  assign result_bits = burst_on ? (acsc_pkg::FULL_BITS - {1'b0, len_sel})
                                : acsc_pkg::FULL_BITS;

  // start selection
  wire [2:0] next_src = next_ctrl[acsc_pkg::SRC_LSB +: 3];
  wire next_pwr = next_ctrl[acsc_pkg::PWR_BIT];
  wire next_burst = next_ctrl[acsc_pkg::BURST_BIT];
  wire start_now = ctrl_wr && next_pwr && !next_burst
                   && (next_src == acsc_pkg::SRC_NOW);
  wire [acsc_pkg::NUM_EDGE_SRC-1:0] start_lines = {timer1_match1_out,
    timer1_match0_out, timer0_match3_out, timer0_match1_out,
    port0_pin22_start, shared_interrupt_start_pin};
  wire [acsc_pkg::NUM_EDGE_SRC-1:0] edge_hit;
  wire edge_mode = (start_src >= acsc_pkg::SRC_FIRST_EDGE);
  wire [2:0] edge_idx = start_src - acsc_pkg::SRC_FIRST_EDGE;
  wire sel_edge = edge_mode && edge_hit[edge_idx];
  // a write in the same cycle wins; the edge belongs to old settings
  wire edge_start = sel_edge && power_on && !burst_on && !ctrl_wr;
  wire burst_run = burst_on && power_on
                   && (start_src == acsc_pkg::SRC_NONE);

  acsc_edge_detect #(
    .N(acsc_pkg::NUM_EDGE_SRC)
  ) u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .sig_in(start_lines),
    .falling(falling_sel),
    .edge_hit(edge_hit)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      conv_start <= 1'b0;
    else
      conv_start <= start_now || edge_start;
  end

  acsc_conv_seq u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .power_on(power_on),
    .start(conv_start),
    .repeat_run(burst_run),
    .clk_div(clk_div),
    .conv_clocks(conv_clocks),
    .conv_tick(conv_tick),
    .busy(conv_busy),
    .done(seq_done)
  );

  // read channel
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire rd_ctrl = (s_axi_araddr == acsc_pkg::CTRL_ADDR);
  wire rd_gdr = (s_axi_araddr == acsc_pkg::GDR_ADDR);
  wire gdr_read = ar_hs && rd_gdr;
  // channel field and reserved bits read zero
  wire [31:0] gdr_value = {done, overrun, 14'h0000, result, 6'h00};
  wire [31:0] rd_value = rd_ctrl ? converter_control : (rd_gdr ? gdr_value : 32'h00000000);

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= acsc_pkg::RESP_OKAY;
    end
    else if (ar_hs)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_value;
      s_axi_rresp <= (rd_ctrl || rd_gdr) ? acsc_pkg::RESP_OKAY : acsc_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // completion flag: a finish in the clearing cycle still sets it
  wire done_clr = gdr_read || ctrl_wr;
  wire next_done = seq_done || (done && !done_clr);
  wire next_overrun = (seq_done && done && burst_on) || (overrun && !gdr_read);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      done <= 1'b0;
      overrun <= 1'b0;
      result <= 10'h000;
    end
    else
    begin
      done <= next_done;
      overrun <= next_overrun;
      if (seq_done)
        result <= core_result;
    end
  end

  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_write_now;
    ctrl_wr && next_pwr && !next_burst && (next_src == acsc_pkg::SRC_NOW);
  endsequence

  sequence s_edge_armed;
    sel_edge && power_on && !burst_on && !ctrl_wr;
  endsequence

  sequence s_flag_read;
    done && gdr_read && !seq_done;
  endsequence

  a_burst_length: assert property (burst_on |-> (conv_clocks + {1'b0, len_sel}) == 4'hb
    && (result_bits + {1'b0, len_sel}) == 4'ha)
    else $error("burst length decode wrong");

  a_soft_length: assert property (!burst_on |-> conv_clocks == 4'hb && result_bits == 4'ha)
    else $error("software conversion not full length");

  a_power_gate: assert property (!power_on && !(ctrl_wr && next_pwr)
    |=> !conv_start && !conv_busy)
    else $error("start while powered down");

  a_no_source: assert property (!ctrl_wr && start_src == 3'h0 |=> !conv_start)
    else $error("start with no source");

  a_burst_block: assert property (burst_on && !ctrl_wr |=> !conv_start)
    else $error("start taken in burst mode");

  a_start_now: assert property (s_write_now |=> conv_start ##1 conv_busy)
    else $error("immediate start missed");

  a_edge_start: assert property (s_edge_armed |=> conv_start)
    else $error("edge did not start conversion");

  a_edge_ignored: assert property (!edge_mode && !ctrl_wr && start_src != 3'h1
    |=> !conv_start)
    else $error("edge used outside edge codes");

  a_power_out: assert property (ctrl_wr && wr_strb[2]
    |=> converter_power_on == $past(wr_data[acsc_pkg::PWR_BIT]))
    else $error("power output mismatch");

  a_done_set: assert property (seq_done |=> done)
    else $error("done flag not set");

  a_done_clear: assert property (s_flag_read |=> !done)
    else $error("done flag not cleared");

  a_tick_rate: assert property (conv_tick && power_on && $stable(clk_div)
    ##1 (power_on && $stable(clk_div)) |-> !conv_tick || clk_div == 8'h00)
    else $error("converter clock too fast");

  a_write_clear: assert property (ctrl_wr && !seq_done |=> !done)
    else $error("write did not clear done");
endmodule : acsc_top

// *** acsc_core_model.sv ***
// far-side model: converter core result source and the six start lines
// assumes the bench sets line levels and reads expected results from RES_BASE
`timescale 1ns/10ps
module acsc_core_model #(
  parameter logic [9:0] RES_BASE = 10'h2a5
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic conv_start,
  input wire logic [5:0] line_req,
  output logic [5:0] start_lines,
  output logic [9:0] core_result
);
  logic [9:0] n_conv;
  // lines are pins and timer outputs, always driven, never floating
  assign start_lines = line_req;
  // one fresh result per start, held until the next start
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      n_conv <= 10'h000;
      core_result <= 10'h3ff;
    end
    else if (conv_start)
    begin
      n_conv <= n_conv + 10'h001;
      core_result <= RES_BASE + n_conv;
    end
  end
endmodule : acsc_core_model

// *** adc_conversion_start_control_tb.sv ***
// self-checking bench for the converter start control block
// assumes acsc_pkg and acsc_core_model are compiled first
`timescale 1ns/10ps
module adc_conversion_start_control_tb;
  localparam logic [9:0] RES_BASE = 10'h2a5;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [5:0] line_req = 6'h00;
  logic [5:0] lines;
  logic [9:0] core_result;
  logic converter_power_on, conv_start, conv_tick, conv_busy;
  logic [3:0] conv_clocks, result_bits;
  logic [7:0] channel_select;
  int n_fail = 0, n_checks = 0, n_starts = 0, n_ticks = 0, n_busy = 0, cyc = 0;

  acsc_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .shared_interrupt_start_pin(lines[0]),
    .port0_pin22_start(lines[1]), .timer0_match1_out(lines[2]), .timer0_match3_out(lines[3]),
    .timer1_match0_out(lines[4]), .timer1_match1_out(lines[5]), .core_result,
    .converter_power_on, .conv_start, .conv_tick, .conv_busy, .conv_clocks, .result_bits,
    .channel_select);
  acsc_core_model #(.RES_BASE(RES_BASE)) model_u (.aclk, .aresetn, .conv_start, .line_req,
    .start_lines(lines), .core_result);

  always #10 aclk = ~aclk;

  task automatic tally_and_finish();
    if (n_fail == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  // event counters; the ceiling cuts a hung handshake short
  always @(posedge aclk)
  begin
    cyc++;
    if (aresetn === 1'b1 && conv_start === 1'b1) n_starts++;
    if (conv_busy === 1'b1 && conv_tick === 1'b1) n_ticks++;
    if (conv_busy === 1'b1) n_busy++;
    if (cyc == 20000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1)
      begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1)
      begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  function automatic logic [31:0] cw(logic [7:0] dv, logic bu, logic [2:0] ln, logic pw,
    logic [2:0] src, logic edg);
    cw = {4'h0, edg, src, 2'h0, pw, 1'b0, ln, bu, dv, 8'h01};
  endfunction : cw

  // start pulse lands one edge after the write, done two after the last tick
  task automatic wait_conv();
    repeat (3) @(posedge aclk);
    while (conv_busy !== 1'b0) @(posedge aclk);
    repeat (3) @(posedge aclk);
  endtask : wait_conv

  logic [31:0] d;
  logic [1:0] r;
  int base, t0, k;

  task automatic t_reset();
    chk("power", 32'h0, converter_power_on);
    chk("clocks", 32'hb, conv_clocks);
    rd(acsc_pkg::CTRL_ADDR, d, r);
    chk("ctrl", acsc_pkg::CTRL_RESET, d);
    chk("rresp", acsc_pkg::RESP_OKAY, r);
  endtask : t_reset

  task automatic t_length();
    for (int l = 0; l < 8; l++)
    begin
      wr(acsc_pkg::CTRL_ADDR, cw(8'h0, 1'b1, l[2:0], 1'b0, 3'h0, 1'b0), r);
      chk("clocks", 32'(11 - l), conv_clocks);
      chk("bits", 32'(10 - l), result_bits);
      chk("channel", 32'h1, channel_select);
      rd(acsc_pkg::CTRL_ADDR, d, r);
      chk("ctrl", cw(8'h0, 1'b1, l[2:0], 1'b0, 3'h0, 1'b0), d);
    end
  endtask : t_length

  task automatic t_start_now();
    base = n_starts;
    t0 = n_ticks;
    // edge bit set on purpose: must not matter for code 001
    wr(acsc_pkg::CTRL_ADDR, cw(8'h2, 1'b0, 3'h5, 1'b1, 3'h1, 1'b1), r);
    chk("power", 32'h1, converter_power_on);
    do @(posedge aclk); while (conv_tick !== 1'b1);
    k = 0;
    do
    begin
      @(posedge aclk);
      k++;
    end while (conv_tick !== 1'b1);
    chk("tick gap", 32'h3, k);
    wait_conv();
    chk("starts", base + 1, n_starts);
    chk("ticks", t0 + 11, n_ticks);
    rd(acsc_pkg::GDR_ADDR, d, r);
    chk("done", 32'h1, d[31]);
    chk("result", 10'(RES_BASE + n_starts - 1), d[15:6]);
    rd(acsc_pkg::GDR_ADDR, d, r);
    chk("done read", 32'h0, d[31]);
    wr(acsc_pkg::CTRL_ADDR, cw(8'h0, 1'b0, 3'h0, 1'b1, 3'h1, 1'b0), r);
    wait_conv();
    wr(acsc_pkg::CTRL_ADDR, cw(8'h0, 1'b0, 3'h0, 1'b1, 3'h0, 1'b0), r);
    rd(acsc_pkg::GDR_ADDR, d, r);
    chk("done write", 32'h0, d[31]);
    base = n_starts;
    repeat (30) @(posedge aclk);
    chk("no source", base, n_starts);
    wr(acsc_pkg::CTRL_ADDR, cw(8'h0, 1'b0, 3'h0, 1'b0, 3'h1, 1'b0), r);
    repeat (30) @(posedge aclk);
    chk("off starts", base, n_starts);
    chk("power off", 32'h0, converter_power_on);
  endtask : t_start_now

  task automatic t_edges();
    for (int s = 0; s < 6; s++)
      for (int e = 0; e < 2; e++)
      begin
        wr(acsc_pkg::CTRL_ADDR, cw(8'h0, 1'b0, 3'h0, 1'b1, 3'h0, 1'b0), r);
        line_req <= {6{e[0]}};
        repeat (8) @(posedge aclk);
        wr(acsc_pkg::CTRL_ADDR, cw(8'h0, 1'b0, 3'h0, 1'b1, 3'(s + 2), e[0]), r);
        base = n_starts;
        // an unselected line must not start anything
        line_req[(s + 1) % 6] <= ~e[0];
        repeat (6) @(posedge aclk);
        line_req[(s + 1) % 6] <= e[0];
        repeat (6) @(posedge aclk);
        line_req[s] <= ~e[0];
        repeat (6) @(posedge aclk);
        chk("edge start", base + 1, n_starts);
        line_req[s] <= e[0];
        wait_conv();
        chk("edge once", base + 1, n_starts);
      end
  endtask : t_edges

  task automatic t_burst();
    base = n_starts;
    t0 = n_busy;
    wr(acsc_pkg::CTRL_ADDR, cw(8'h0, 1'b1, 3'h3, 1'b1, 3'h1, 1'b0), r);
    repeat (60) @(posedge aclk);
    chk("burst src", t0, n_busy);
    chk("burst starts", base, n_starts);
    wr(acsc_pkg::CTRL_ADDR, cw(8'h0, 1'b1, 3'h3, 1'b1, 3'h0, 1'b0), r);
    repeat (60) @(posedge aclk);
    chk("burst runs", 32'h1, n_busy > t0);
    wr(acsc_pkg::CTRL_ADDR, cw(8'h0, 1'b0, 3'h0, 1'b1, 3'h0, 1'b0), r);
    wait_conv();
  endtask : t_burst

  task automatic t_unmapped();
    wr(32'he0034008, 32'h00200000, r);
    chk("bresp", acsc_pkg::RESP_SLVERR, r);
    rd(32'he0034008, d, r);
    chk("rresp", acsc_pkg::RESP_SLVERR, r);
    chk("rdata", 32'h0, d);
    rd(acsc_pkg::CTRL_ADDR, d, r);
    chk("ctrl kept", cw(8'h0, 1'b0, 3'h0, 1'b1, 3'h0, 1'b0), d);
  endtask : t_unmapped

  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_length();
    t_start_now();
    t_edges();
    t_burst();
    t_unmapped();
    tally_and_finish();
  end
endmodule : adc_conversion_start_control_tb
